// ===== src/nvm_checksum_pkg.sv
package nvm_checksum_pkg;

  // Control/status page 5 register indices; 0x8D is not a multiple of four,
  // so each offset is kept as an index and the byte address is four times it.
  localparam logic [7:0] CS_PAGE = 8'h05;
  localparam logic [7:0] IDX_TRIGGER = 8'h8A;
  localparam logic [7:0] IDX_STATUS = 8'h8C;
  localparam logic [7:0] IDX_COMPUTED = 8'h8D;
  // Index chosen for the reference-byte image (lives in the memory, not a CSR)
  localparam logic [7:0] IDX_REFERENCE = 8'h8E;

  // Nonvolatile memory location of the reference byte
  localparam logic [3:0] NVM_REF_PAGE = 4'hF;
  localparam logic [2:0] NVM_REF_OFFSET = 3'h7;
  localparam logic [7:0] REF_RESET = 8'hB8;

  // Memory geometry: 16 pages of 8 bytes
  localparam int NVM_BYTES = 128;
  localparam logic [6:0] NVM_LAST = 7'h7F;
  localparam logic [6:0] NVM_REF_ADDR = {NVM_REF_PAGE, NVM_REF_OFFSET};

  // Status and trigger field positions
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_MATCH_BIT = 1;
  localparam int TRIG_BIT = 0;

  // Checksum polynomial x^8+x^2+x+1, seed zero
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  // Active window: one cycle per memory byte plus the finish cycle
  localparam logic [7:0] ACTIVE_CYCLES = 8'h81;

  typedef enum logic [1:0] {IDLE, SCAN, DONE} chk_state_e;

endpackage : nvm_checksum_pkg

// ===== src/crc8_step.sv
// One byte step of the bitwise MSB-first checksum
module crc8_step (
  // Running value and new byte
  input wire logic [7:0] crcIn,
  input wire logic [7:0] dataIn,
  // Next value
  output logic [7:0] crcOut
);
  import nvm_checksum_pkg::*;

  // Eight shift-and-fold steps, unrolled by a loop
  always_comb begin
    logic [7:0] c;
    c = crcIn ^ dataIn;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    crcOut = c;
  end

endmodule : crc8_step

// ===== src/nvm_checksum_verifier.sv
// Notes on behaviour
// R1: Match bit is one when stored reference equals computed checksum, else zero.
// R2: Check-active bit is one while a check runs, zero otherwise; resets zero.
// R3: Computed checksum is a read-only 8-bit field, undefined until first check. Here it resets to zero.
// R4: Computed checksum sits at page 5 offset 0x8D, no memory copy.
// R5: Reference byte lives in memory page 15 offset 7, default 0xB8.
// R6: Status upper six bits are read-only and read as zero.
// R7: Writing one to the trigger bit starts a check; zero does nothing. Here a one written while a check runs is ignored.
// R8: At finish, value and match update together and active clears same cycle.
//
// Implementation choice: the APB slave port.
module nvm_checksum_verifier (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status mirrors
  output logic checksumMatch,
  output logic checksum_check_active
);
  import nvm_checksum_pkg::*;

  logic [7:0] nvmMem [NVM_BYTES];
  chk_state_e state_reg;
  logic [6:0] scanAddr_reg;
  logic [7:0] crc_reg;
  logic [7:0] crcNext;
  logic [7:0] checksum_computed_reg;
  logic match_reg;
  logic [7:0] idx;
  logic idxAligned;
  logic wrStrobe;
  logic hit;
  logic startReq;
  logic [7:0] activeLen_reg;

  // Register index from the word address
  assign idx = paddr[9:2];
  assign idxAligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign hit = idxAligned && (idx == IDX_TRIGGER || idx == IDX_STATUS ||
               idx == IDX_COMPUTED || idx == IDX_REFERENCE);
  assign wrStrobe = psel && penable && pwrite;
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign startReq = wrStrobe && hit && (idx == IDX_TRIGGER) && pwdata[TRIG_BIT]; // [R7]

  crc8_step u_step (
    .crcIn(crc_reg),
    .dataIn(nvmMem[scanAddr_reg]),
    .crcOut(crcNext)
  );

  // Memory image: only the reference byte is software-writable here
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NVM_BYTES; i++) begin
        nvmMem[i] <= 8'h00;
      end
      nvmMem[NVM_REF_ADDR] <= REF_RESET; // [R5]
    end else if (wrStrobe && hit && idx == IDX_REFERENCE) begin
      nvmMem[NVM_REF_ADDR] <= pwdata[7:0]; // [R5]
    end
  end

  // Scan sequencer; a trigger during a scan is ignored to keep the result coherent
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= IDLE;
      scanAddr_reg <= 7'h00;
      crc_reg <= CRC_SEED;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (startReq) begin // [R7]
            state_reg <= SCAN;
            scanAddr_reg <= 7'h00;
            crc_reg <= CRC_SEED;
          end
        end
        SCAN: begin
          crc_reg <= crcNext;
          scanAddr_reg <= scanAddr_reg + 7'h01;
          if (scanAddr_reg == NVM_LAST) begin
            state_reg <= DONE;
          end
        end
        DONE: begin
          state_reg <= IDLE; // [R8]
        end
        // The spare code would otherwise lock the sequencer up
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Result and match land together in the same cycle active clears
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      match_reg <= 1'b0; // [R1]
      checksum_computed_reg <= 8'h00; // [R3] undefined by spec, zero here
    end else if (state_reg == DONE) begin
      checksum_computed_reg <= crc_reg; // [R8]
      match_reg <= (nvmMem[NVM_REF_ADDR] == crc_reg); // [R1]
    end
  end

  assign checksum_check_active = (state_reg != IDLE); // [R2]
  assign checksumMatch = match_reg;

  // Length of the current active window, kept only for the checks below
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      activeLen_reg <= 8'h00;
    end else if (checksum_check_active) begin
      activeLen_reg <= activeLen_reg + 8'h01;
    end else begin
      activeLen_reg <= 8'h00;
    end
  end

  // Read data, registered; reserved bits read as zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (idxAligned) begin
        unique case (idx)
          IDX_STATUS: begin
            prdata[ST_MATCH_BIT] <= match_reg; // [R6]
            prdata[ST_ACTIVE_BIT] <= checksum_check_active;
          end
          IDX_COMPUTED: prdata[7:0] <= checksum_computed_reg; // [R4]
          IDX_REFERENCE: prdata[7:0] <= nvmMem[NVM_REF_ADDR];
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Start leads to active on the next edge
  property p_start_active;
    @(posedge ref_clk) disable iff (!reset_n)
      (startReq && state_reg == IDLE) |=> checksum_check_active;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start missed"); // [R7]

  // Active window lasts one cycle per byte plus the finish cycle; a reset cuts it short
  property p_active_len;
    @(posedge ref_clk) disable iff (!reset_n)
      ($fell(checksum_check_active) && $past(reset_n)) |-> (activeLen_reg == ACTIVE_CYCLES);
  endproperty
  a_active_len: assert property (p_active_len) else $error("active too short"); // [R2]

  // On finish, active falls and result matches the scan
  property p_finish;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_reg == DONE) |=> (!checksum_check_active &&
        checksum_computed_reg == $past(crc_reg) &&
        match_reg == ($past(nvmMem[NVM_REF_ADDR]) == $past(crc_reg)));
  endproperty
  a_finish: assert property (p_finish) else $error("finish not coherent"); // [R8]

  // Match only changes at finish
  property p_match_stable;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_reg != DONE) |=> $stable(match_reg);
  endproperty
  a_match_stable: assert property (p_match_stable) else $error("match moved"); // [R1]

  // Computed value only changes at finish
  property p_value_stable;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_reg != DONE) |=> $stable(checksum_computed_reg);
  endproperty
  a_value_stable: assert property (p_value_stable) else $error("value moved"); // [R3]

  // Status read returns reserved bits as zero
  property p_status_read;
    @(posedge ref_clk) disable iff (!reset_n)
      (psel && !penable && !pwrite && idxAligned && idx == IDX_STATUS)
        |=> (prdata[31:2] == 30'h0 && prdata[ST_MATCH_BIT] == $past(match_reg));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read bad"); // [R6]

  // Computed register read at its index
  property p_comp_read;
    @(posedge ref_clk) disable iff (!reset_n)
      (psel && !penable && !pwrite && idxAligned && idx == IDX_COMPUTED)
        |=> prdata == {24'h0, $past(checksum_computed_reg)};
  endproperty
  a_comp_read: assert property (p_comp_read) else $error("computed read bad"); // [R4]

  // Zero in the trigger bit never starts a scan
  property p_zero_trig;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_reg == IDLE && !startReq) |=> !checksum_check_active;
  endproperty
  a_zero_trig: assert property (p_zero_trig) else $error("spurious start"); // [R7]

  // Reference write lands in the memory byte
  property p_ref_write;
    @(posedge ref_clk) disable iff (!reset_n)
      (wrStrobe && idxAligned && idx == IDX_REFERENCE)
        |=> nvmMem[NVM_REF_ADDR] == $past(pwdata[7:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference write lost"); // [R5]

  // The active window never runs past its fixed length
  property p_active_cap;
    @(posedge ref_clk) disable iff (!reset_n)
      checksum_check_active |-> (activeLen_reg < ACTIVE_CYCLES);
  endproperty
  a_active_cap: assert property (p_active_cap) else $error("active too long"); // [R2]

  // Reference read returns the stored memory byte
  property p_ref_read;
    @(posedge ref_clk) disable iff (!reset_n)
      (psel && !penable && !pwrite && idxAligned && idx == IDX_REFERENCE)
        |=> prdata == {24'h0, $past(nvmMem[NVM_REF_ADDR])};
  endproperty
  a_ref_read: assert property (p_ref_read) else $error("reference read bad"); // [R5]

endmodule : nvm_checksum_verifier

// ===== testbench/nvm_checksum_verifier_test.sv
module nvm_checksum_verifier_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_checksum_pkg::*;
  `define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic checksumMatch;
  logic checksum_check_active;
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;
  nvm_checksum_verifier i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .checksumMatch(checksumMatch),
    .checksum_check_active(checksum_check_active));
  // Reference checksum of the memory image, kept apart from the design's own step
  function automatic logic [7:0] mem_crc(input logic [7:0] refByte);
    logic [7:0] r;
    r = CRC_SEED;
    for (int a = 0; a < NVM_BYTES; a++) begin
      r = r ^ ((a == int'(NVM_REF_ADDR)) ? refByte : 8'h00);
      for (int b = 0; b < 8; b++) begin
        r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction : mem_crc
  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Values right after reset
  task automatic t_reset();
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, IDX_REFERENCE, 32'h0);
    `CHK(rd, {24'h0, REF_RESET})
  endtask : t_reset
  // Read-only places and an unmapped index
  task automatic t_readonly();
    apb(1'b1, IDX_STATUS, 32'h000000FF);
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b1, IDX_COMPUTED, 32'h00000055);
    apb(1'b0, IDX_COMPUTED, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 8'h00, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, IDX_TRIGGER, 32'h00000000);
    repeat (3) @(posedge ref_clk);
    `CHK(checksum_check_active, 1'b0)
  endtask : t_readonly
  // Full check with a given reference byte; active length and result flags
  task automatic t_check(input logic [7:0] refByte);
    logic [7:0] exp;
    int n;
    exp = mem_crc(refByte);
    n = 0;
    apb(1'b1, IDX_REFERENCE, {24'h0, refByte});
    apb(1'b1, IDX_TRIGGER, 32'h00000001);
    // Count is bounded by the scan length plus slack, so a stuck flag shows
    repeat (200) begin
      @(posedge ref_clk);
      if (checksum_check_active === 1'b1) n++;
    end
    `CHK(n, ACTIVE_CYCLES)
    apb(1'b0, IDX_COMPUTED, 32'h0);
    `CHK(rd, {24'h0, exp})
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(rd, {30'h0, exp == refByte, 1'b0})
    `CHK(checksumMatch, exp == refByte)
  endtask : t_check
  // Reset in mid-scan ends the check and restores the defaults
  task automatic t_abort();
    apb(1'b1, IDX_REFERENCE, 32'h00000011);
    apb(1'b1, IDX_TRIGGER, 32'h00000001);
    repeat (20) @(posedge ref_clk);
    `CHK(checksum_check_active, 1'b1)
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    `CHK(checksum_check_active, 1'b0)
    apb(1'b0, IDX_REFERENCE, 32'h0);
    `CHK(rd, {24'h0, REF_RESET})
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, IDX_COMPUTED, 32'h0);
    `CHK(rd, 32'h00000000)
  endtask : t_abort
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_readonly();
    t_check(REF_RESET);
    t_check(8'h00);
    t_check(8'h5A);
    t_abort();
    summarize();
  end
endmodule : nvm_checksum_verifier_test
